// *** tsc_flags_top.sv ***
// Timer and serial control flag bank behind a classic Wishbone slave.
//
// How it works
// - Edge mode: falling pin edge sets flag.
// - Edge flag clears when interrupt processed.
// - Type bit: one edge, zero level.
// - Each received frame loads ninth-bit status.
// - Hardware sets transmit flag; software clears.
// - Hardware sets receive flag; software clears.
`timescale 1ns/1ps
`default_nettype none
module tsc_flags_top
    import tsc_pkg::*;
(
    // Clock, reset, enable
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    input  wire logic              clkEn,
    // Wishbone slave
    input  wire logic              wbCyc,
    input  wire logic              wbStb,
    input  wire logic              wbWe,
    input  wire logic [ADDR_W-1:0] wbAdr,
    input  wire logic [3:0]        wbSel,
    input  wire logic [31:0]       wbDatWr,
    output logic      [31:0]       wbDatRd,
    output logic                   wbAck,
    // External interrupt pins and processing strobes
    input  wire logic [1:0]        extIrqPin,
    input  wire logic [1:0]        extIrqAck,
    output logic      [1:0]        extIrqRequest,
    // Timer events
    input  wire logic [1:0]        timerRollover,
    input  wire logic [1:0]        timerIrqAck,
    output logic      [1:0]        timerRunBit,
    output logic      [1:0]        timerOverflowFlag,
    // Serial events and controls
    input  wire logic              txByteDone,
    input  wire logic              rxByteDone,
    input  wire logic              rxNinthData,
    output logic      [1:0]        serialMode,
    output logic                   multiprocFilterBit,
    output logic                   receiveEnable,
    output logic                   transmitNinthBit,
    output logic                   serialIrqRequest
);
    logic [7:0]  tmrCtrl_reg;
    logic [7:0]  tmrCtrl_next;
    logic [7:0]  serCtrl_reg;
    logic [7:0]  serCtrl_next;
    logic        ack_reg;
    logic        ack_next;
    logic [31:0] rdData_reg;
    logic [31:0] rdData_next;
    logic        wrTmr;
    logic        wrSer;
    logic [1:0]  edgeFlag;
    logic [7:0]  tmrView;
    logic [1:0]  typeBits;
    logic [1:0]  edgeData;

    assign wrTmr = wbCyc & wbStb & wbWe & ack_reg & wbSel[0]
                 & (wbAdr == TMR_CTRL_ADDR);
    assign wrSer = wbCyc & wbStb & wbWe & ack_reg & wbSel[0]
                 & (wbAdr == SER_CTRL_ADDR);

    assign typeBits = {tmrCtrl_reg[EXT1_TYPE_BIT], tmrCtrl_reg[EXT0_TYPE_BIT]};
    assign edgeData = {wbDatWr[EXT1_EDGE_BIT], wbDatWr[EXT0_EDGE_BIT]};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ext
            tsc_ext_irq_chan u_chan (
                .sysClk     (sys_clk),
                .rst_n      (rst_n),
                .clkEn      (clkEn),
                .irqPin     (extIrqPin[gi]),
                .typeEdge   (typeBits[gi]),
                .swWrite    (wrTmr),
                .swData     (edgeData[gi]),
                .irqAck     (extIrqAck[gi]),
                .edgeFlag   (edgeFlag[gi]),
                .irqRequest (extIrqRequest[gi])
            );
        end
    endgenerate

    always_comb begin
        tmrCtrl_next = tmrCtrl_reg;
        if (wrTmr) begin
            tmrCtrl_next = wbDatWr[7:0];
        end
        if (timerIrqAck[0]) begin
            tmrCtrl_next[TMR0_OVF_BIT] = 1'b0;
        end
        if (timerIrqAck[1]) begin
            tmrCtrl_next[TMR1_OVF_BIT] = 1'b0;
        end
        if (timerRollover[0] & tmrCtrl_reg[TMR0_RUN_BIT]) begin
            tmrCtrl_next[TMR0_OVF_BIT] = 1'b1;
        end
        if (timerRollover[1] & tmrCtrl_reg[TMR1_RUN_BIT]) begin
            tmrCtrl_next[TMR1_OVF_BIT] = 1'b1;
        end
        tmrCtrl_next[EXT0_EDGE_BIT] = 1'b0;
        tmrCtrl_next[EXT1_EDGE_BIT] = 1'b0;
    end

    always_comb begin
        serCtrl_next = serCtrl_reg;
        if (wrSer) begin
            serCtrl_next = wbDatWr[7:0];
        end
        if (rxByteDone) begin
            serCtrl_next[RX_NINTH_BIT] = rxNinthData;
        end
        if (txByteDone) begin
            serCtrl_next[TX_DONE_BIT] = 1'b1;
        end
        if (rxByteDone) begin
            serCtrl_next[RX_DONE_BIT] = 1'b1;
        end
    end

    always_comb begin
        tmrView                = tmrCtrl_reg;
        tmrView[EXT0_EDGE_BIT] = edgeFlag[0];
        tmrView[EXT1_EDGE_BIT] = edgeFlag[1];
        ack_next    = wbCyc & wbStb & ~ack_reg;
        rdData_next = rdData_reg;
        if (ack_next) begin
            case (wbAdr)
                TMR_CTRL_ADDR: rdData_next = {24'h00_0000, tmrView};
                SER_CTRL_ADDR: rdData_next = {24'h00_0000, serCtrl_reg};
                default:       rdData_next = UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tmrCtrl_reg <= TMR_CTRL_RST;
            serCtrl_reg <= SER_CTRL_RST;
            ack_reg     <= 1'b0;
            rdData_reg  <= UNMAPPED_READ;
        end else if (clkEn) begin
            tmrCtrl_reg <= tmrCtrl_next;
            serCtrl_reg <= serCtrl_next;
            ack_reg     <= ack_next;
            rdData_reg  <= rdData_next;
        end
    end

    assign wbAck   = ack_reg;
    assign wbDatRd = rdData_reg;
    assign timerRunBit        = {tmrCtrl_reg[TMR1_RUN_BIT], tmrCtrl_reg[TMR0_RUN_BIT]};
    assign timerOverflowFlag  = {tmrCtrl_reg[TMR1_OVF_BIT], tmrCtrl_reg[TMR0_OVF_BIT]};
    assign serialMode         = {serCtrl_reg[SER_MODE_HI_BIT], serCtrl_reg[SER_MODE_LO_BIT]};
    assign multiprocFilterBit = serCtrl_reg[MULTIPROC_BIT];
    assign receiveEnable      = serCtrl_reg[RX_ENABLE_BIT];
    assign transmitNinthBit   = serCtrl_reg[TX_NINTH_BIT];
    assign serialIrqRequest   = serCtrl_reg[TX_DONE_BIT] | serCtrl_reg[RX_DONE_BIT];
endmodule // tsc_flags_top
`default_nettype wire

// *** tsc_pkg.sv ***
// Package with register map, field positions and reset values of the flag bank.
`default_nettype none
package tsc_pkg;
    localparam int          ADDR_W        = 4;
    localparam logic [3:0]  TMR_CTRL_ADDR = 4'h0;
    localparam logic [3:0]  SER_CTRL_ADDR = 4'h4;
    localparam logic [7:0]  TMR_CTRL_RST  = 8'h00;
    localparam logic [7:0]  SER_CTRL_RST  = 8'h00;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
    localparam int          WORD_LSB      = 2;
    // Timer and external interrupt control fields.
    localparam int TMR1_OVF_BIT  = 7;
    localparam int TMR1_RUN_BIT  = 6;
    localparam int TMR0_OVF_BIT  = 5;
    localparam int TMR0_RUN_BIT  = 4;
    localparam int EXT1_EDGE_BIT = 3;
    localparam int EXT1_TYPE_BIT = 2;
    localparam int EXT0_EDGE_BIT = 1;
    localparam int EXT0_TYPE_BIT = 0;
    // Serial port control fields.
    localparam int SER_MODE_HI_BIT  = 7;
    localparam int SER_MODE_LO_BIT  = 6;
    localparam int MULTIPROC_BIT    = 5;
    localparam int RX_ENABLE_BIT    = 4;
    localparam int TX_NINTH_BIT     = 3;
    localparam int RX_NINTH_BIT     = 2;
    localparam int TX_DONE_BIT      = 1;
    localparam int RX_DONE_BIT      = 0;
endpackage
`default_nettype wire

// *** tsc_ext_irq_chan.sv ***
// One external interrupt input channel with edge flag and trigger type.
`timescale 1ns/1ps
`default_nettype none
module tsc_ext_irq_chan (
    // Clock and reset
    input  wire logic sysClk,
    input  wire logic rst_n,
    input  wire logic clkEn,
    // Pin and control
    input  wire logic irqPin,
    input  wire logic typeEdge,
    input  wire logic swWrite,
    input  wire logic swData,
    input  wire logic irqAck,
    // Results
    output logic      edgeFlag,
    output logic      irqRequest
);
    logic pinPrev_reg;
    logic pinPrev_next;
    logic flag_reg;
    logic flag_next;
    logic fallEdge;

    always_comb begin
        pinPrev_next = irqPin;
        fallEdge     = typeEdge & pinPrev_reg & ~irqPin;
        flag_next    = flag_reg;
        if (swWrite) begin
            flag_next = swData;
        end
        if (irqAck) begin
            flag_next = 1'b0;
        end
        if (fallEdge) begin
            flag_next = 1'b1;
        end
    end

    always_ff @(posedge sysClk or negedge rst_n) begin
        if (!rst_n) begin
            pinPrev_reg <= 1'b1;
            flag_reg    <= 1'b0;
        end else if (clkEn) begin
            pinPrev_reg <= pinPrev_next;
            flag_reg    <= flag_next;
        end
    end

    assign edgeFlag   = flag_reg;
    assign irqRequest = typeEdge ? flag_reg : ~irqPin;
endmodule // tsc_ext_irq_chan
`default_nettype wire

// *** tsc_flags_assertions.sv ***
// Checker for the flag bank port behaviour.
`timescale 1ns/1ps
`default_nettype none
module tsc_flags_checker (
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire logic       clkEn,
    input wire logic       wbCyc,
    input wire logic       wbStb,
    input wire logic       wbAck,
    input wire logic [1:0] extIrqPin,
    input wire logic [1:0] extIrqAck,
    input wire logic [1:0] extIrqRequest,
    input wire logic [1:0] timerRollover,
    input wire logic [1:0] timerIrqAck,
    input wire logic [1:0] timerRunBit,
    input wire logic [1:0] timerOverflowFlag,
    input wire logic       txByteDone,
    input wire logic       serialIrqRequest
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n || !clkEn);
    a_ack_next_cycle: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
        else $error("ack late");
    a_ack_one_pulse: assert property (wbAck |=> !wbAck) else $error("ack too long");
    a_edge_sets_req: assert property ($fell(extIrqPin[0]) |=> extIrqRequest[0] || extIrqPin[0])
        else $error("edge lost");
    a_ack_clears_edge: assert property (extIrqAck[1] && extIrqPin[1] && !wbAck
        |=> !extIrqRequest[1] || !extIrqPin[1]) else $error("edge kept");
    a_ovf_when_run: assert property (timerRollover[0] && timerRunBit[0] |=> timerOverflowFlag[0])
        else $error("overflow lost");
    a_ovf_stopped: assert property (timerRollover[1] && !timerRunBit[1] && !timerOverflowFlag[1]
        && !wbAck |=> !timerOverflowFlag[1]) else $error("stopped overflow");
    a_ovf_ack_clr: assert property (timerIrqAck[0] && !timerRollover[0] && !wbAck
        |=> !timerOverflowFlag[0]) else $error("overflow kept");
    a_tx_sets_flag: assert property (txByteDone |=> serialIrqRequest)
        else $error("tx flag lost");
    a_flags_hold: assert property (serialIrqRequest && !wbAck |=> serialIrqRequest)
        else $error("flag self cleared");
endmodule // tsc_flags_checker
bind tsc_flags_top tsc_flags_checker chk_u (.sys_clk, .rst_n, .clkEn, .wbCyc, .wbStb,
    .wbAck, .extIrqPin, .extIrqAck, .extIrqRequest, .timerRollover, .timerIrqAck,
    .timerRunBit, .timerOverflowFlag, .txByteDone, .serialIrqRequest);
`default_nettype wire

// *** tsc_irq_peer.sv ***
// Model of the interrupt pins and the serial line peer.
`timescale 1ns/1ps
`default_nettype none
module tsc_irq_peer (
    input  wire logic       clk,
    output logic      [1:0] pin,
    output logic            rxDone,
    output logic            rxBit
);
    initial begin
        pin = 2'h3;
        rxDone = 1'b0;
        rxBit = 1'b0;
    end
    task automatic setPin(input int i, input logic v);
        @(posedge clk) pin[i] <= v;
    endtask
    task automatic frame(input logic b);
        @(posedge clk) rxDone <= 1'b1;
        rxBit <= b;
        @(posedge clk) rxDone <= 1'b0;
        rxBit <= ~b;
    endtask
endmodule // tsc_irq_peer
`default_nettype wire

// *** tsc_flags_top_tb_top.sv ***
// Testbench for the flag bank.
`timescale 1ns/1ps
`default_nettype none
module tsc_flags_top_tb_top;
    import tsc_pkg::*;
    logic sys_clk = 0, rst_n = 0, wbCyc = 0, wbStb = 0, wbWe = 0, wbAck, txD = 0, rxD, rxB;
    logic [3:0] wbAdr = 4'h0;
    logic [31:0] wbDatWr = 32'h0, wbDatRd;
    logic [1:0] pin, iAck = 0, iReq, tRoll = 0, tAck = 0, tRun, tOvf, sMode;
    logic mpf, ren, tx9, sIrq;
    int n_fail = 0, total_checks = 0;
    always #4 sys_clk = ~sys_clk;
    tsc_irq_peer peer_u (.clk(sys_clk), .pin(pin), .rxDone(rxD), .rxBit(rxB));
    tsc_flags_top dut_u (.sys_clk, .rst_n, .clkEn(1'b1), .wbCyc, .wbStb, .wbWe, .wbAdr,
        .wbSel(4'hF), .wbDatWr, .wbDatRd, .wbAck, .extIrqPin(pin), .extIrqAck(iAck),
        .extIrqRequest(iReq), .timerRollover(tRoll), .timerIrqAck(tAck), .timerRunBit(tRun),
        .timerOverflowFlag(tOvf), .txByteDone(txD), .rxByteDone(rxD), .rxNinthData(rxB),
        .serialMode(sMode), .multiprocFilterBit(mpf), .receiveEnable(ren),
        .transmitNinthBit(tx9), .serialIrqRequest(sIrq));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        total_checks++;
        if (s !== e) begin
            $display("BAD %s exp %h got %h", n, e, s);
            n_fail++;
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d,
                      output logic [7:0] q);
        @(posedge sys_clk) {wbCyc, wbStb, wbWe, wbAdr, wbDatWr} <= {2'h3, w, a, 24'h0, d};
        do @(posedge sys_clk); while (wbAck !== 1'b1);
        q = wbDatRd[7:0];
        {wbCyc, wbStb} <= 2'h0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] q;
        wb(1'b0, a, 8'h00, q);
        chk("reg", e, q);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic s_ext;
        wr(TMR_CTRL_ADDR, 8'h05);
        peer_u.setPin(0, 1'b0);
        peer_u.setPin(0, 1'b1);
        rd(TMR_CTRL_ADDR, 8'h07);
        @(posedge sys_clk) iAck <= 2'h3;
        @(posedge sys_clk) iAck <= 2'h0;
        @(negedge sys_clk) chk("irq", 8'h00, {6'h0, iReq});
        wr(TMR_CTRL_ADDR, 8'h01);
        peer_u.setPin(1, 1'b0);
        @(negedge sys_clk) chk("irq", 8'h02, {6'h0, iReq});
        rd(TMR_CTRL_ADDR, 8'h01);
        peer_u.setPin(1, 1'b1);
    endtask
    task automatic s_timer;
        wr(TMR_CTRL_ADDR, 8'h10);
        @(posedge sys_clk) tRoll <= 2'h3;
        @(posedge sys_clk) tRoll <= 2'h0;
        @(negedge sys_clk) chk("ovf", 8'h01, {6'h0, tOvf});
        chk("run", 8'h01, {6'h0, tRun});
        rd(TMR_CTRL_ADDR, 8'h30);
        @(posedge sys_clk) tAck <= 2'h1;
        @(posedge sys_clk) tAck <= 2'h0;
        @(negedge sys_clk) chk("ovf", 8'h00, {6'h0, tOvf});
    endtask
    task automatic s_serial;
        @(posedge sys_clk) txD <= 1'b1;
        @(posedge sys_clk) txD <= 1'b0;
        rd(SER_CTRL_ADDR, 8'h02);
        peer_u.frame(1'b1);
        rd(SER_CTRL_ADDR, 8'h07);
        wr(SER_CTRL_ADDR, 8'h00);
        rd(SER_CTRL_ADDR, 8'h00);
        peer_u.frame(1'b0);
        rd(SER_CTRL_ADDR, 8'h01);
        @(negedge sys_clk) chk("sirq", 8'h01, {7'h0, sIrq});
        wr(SER_CTRL_ADDR, 8'hF8);
        @(negedge sys_clk) chk("serout", 8'h3E, {2'h0, sMode, mpf, ren, tx9, sIrq});
        wr(4'h8, 8'hFF);
        rd(4'h8, 8'h00);
    endtask
    task automatic report_and_stop;
        if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(TMR_CTRL_ADDR, TMR_CTRL_RST[7:0]);
        rd(SER_CTRL_ADDR, SER_CTRL_RST[7:0]);
        s_ext();
        s_timer();
        s_serial();
        report_and_stop();
    end
    initial begin
        #100000;
        n_fail++;
        report_and_stop();
    end
endmodule // tsc_flags_top_tb_top
`default_nettype wire
